// ---- src/scanner_status_telegram_builder.sv ----
`timescale 1ns/10ps
// Function
// R01 - 32-bit scan counter in bytes 8-11
// R02 - Counter starts from zero after power-up
// R03 - Byte 12 bit 7: function A active
// R04 - Byte 12 bit 6: A warning field free
// R05 - Byte 12 bit 5: A protective field free
// R06 - Byte 12 bit 4: A restart interlock engaged
// R07 - Byte 12 bit 3: A safety output on
// R08 - Bytes 13-14: A bank and pair numbers
// R09 - Byte 15 bits 7-4: A segment states
// R10 - Byte 15 bits 3-2: A pairs chosen
// R11 - Byte 16 bit 7: function B active
// R12 - Byte 16 bit 6: B warning field free
// R13 - Byte 16 bit 5: B protective field free
// R14 - Byte 16 bits 4-3: B lock, output
// R15 - Bytes 17-18: B bank and pair numbers
// R16 - Byte 19 bits 7-4: B segment states
// R17 - Byte 19 bits 3-2: B pairs chosen
// R18 - Reserved bits always sent as zero
// R19 - All fields captured from same scan
module scanner_status_telegram_builder (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Scan timing: pulse at the end of each completed scan.
	input wire logic scan_done,
	// Protective function A status.
	input wire logic func_a_active,
	input wire logic func_a_warn_field_state,
	input wire logic func_a_prot_field_state,
	input wire logic func_a_restart_lock,
	input wire logic func_a_safety_switching_output,
	// Protective function A selection.
	input wire logic [3:0] func_a_bank_sel,
	input wire logic [3:0] func_a_pair_sel1,
	input wire logic [3:0] func_a_pair_sel2,
	input wire logic [3:0] func_a_pair_sel3,
	// Protective function A output signals.
	input wire logic func_a_warn_seg1_state,
	input wire logic func_a_warn_seg2_state,
	input wire logic func_a_prot_seg1_state,
	input wire logic func_a_prot_seg2_state,
	input wire logic func_a_defined_pair1_chosen,
	input wire logic func_a_defined_pair2_chosen,
	// Protective function B status.
	input wire logic func_b_active,
	input wire logic func_b_warn_field_state,
	input wire logic func_b_prot_field_state,
	input wire logic func_b_restart_lock,
	input wire logic func_b_safety_switching_output,
	// Protective function B selection.
	input wire logic [3:0] func_b_bank_sel,
	input wire logic [3:0] func_b_pair_sel1,
	input wire logic [3:0] func_b_pair_sel2,
	input wire logic [3:0] func_b_pair_sel3,
	// Protective function B output signals.
	input wire logic func_b_warn_seg1_state,
	input wire logic func_b_warn_seg2_state,
	input wire logic func_b_prot_seg1_state,
	input wire logic func_b_prot_seg2_state,
	input wire logic func_b_defined_pair1_chosen,
	input wire logic func_b_defined_pair2_chosen,
	// Telegram snapshot, bytes 8 to 19, byte 8 in the low lane.
	output logic [8*telegram_pkg::SECTION_BYTES-1:0] telegram_bytes,
	output logic telegram_valid,
	output logic telegram_update,
	output logic [31:0] scan_count,
	output logic selection_range_error
);
	import telegram_pkg::*;

	// ****************************************
	// Field packing
	// ****************************************
	// Packed bytes from the helpers first, then the registered state.
	logic [7:0] a_status;
	logic [7:0] a_out;
	logic [7:0] a_sel0;
	logic [7:0] a_sel1;
	logic a_bad;
	logic [7:0] b_status;
	logic [7:0] b_out;
	logic [7:0] b_sel0;
	logic [7:0] b_sel1;
	logic b_bad;
	logic [31:0] scan_r;
	logic [31:0] scan_nxt;
	logic [8*SECTION_BYTES-1:0] snap_r;
	logic [8*SECTION_BYTES-1:0] snap_nxt;
	logic valid_r;
	logic update_r;
	logic range_err_r;

	// Function A bytes 12 and 15.
	status_byte_pack u_pack_a (
		.active(func_a_active), // R03
		.warn_field_state(func_a_warn_field_state), // R04
		.prot_field_state(func_a_prot_field_state), // R05
		.restart_lock(func_a_restart_lock), // R06
		.safety_switching_output(func_a_safety_switching_output), // R07
		.warn_seg1_state(func_a_warn_seg1_state), // R09
		.warn_seg2_state(func_a_warn_seg2_state),
		.prot_seg1_state(func_a_prot_seg1_state),
		.prot_seg2_state(func_a_prot_seg2_state),
		.defined_pair1_chosen(func_a_defined_pair1_chosen), // R10
		.defined_pair2_chosen(func_a_defined_pair2_chosen),
		.status_byte(a_status),
		.out_byte(a_out)
	);

	// Function B bytes 16 and 19.
	status_byte_pack u_pack_b (
		.active(func_b_active), // R11
		.warn_field_state(func_b_warn_field_state), // R12
		.prot_field_state(func_b_prot_field_state), // R13
		.restart_lock(func_b_restart_lock), // R14
		.safety_switching_output(func_b_safety_switching_output), // R14
		.warn_seg1_state(func_b_warn_seg1_state), // R16
		.warn_seg2_state(func_b_warn_seg2_state),
		.prot_seg1_state(func_b_prot_seg1_state),
		.prot_seg2_state(func_b_prot_seg2_state),
		.defined_pair1_chosen(func_b_defined_pair1_chosen), // R17
		.defined_pair2_chosen(func_b_defined_pair2_chosen),
		.status_byte(b_status),
		.out_byte(b_out)
	);

	// Function A bytes 13 and 14.
	selection_pack u_sel_a (
		.bank_sel(func_a_bank_sel), // R08
		.pair_sel1(func_a_pair_sel1),
		.pair_sel2(func_a_pair_sel2),
		.pair_sel3(func_a_pair_sel3),
		.sel_byte0(a_sel0),
		.sel_byte1(a_sel1),
		.out_of_range(a_bad)
	);

	// Function B bytes 17 and 18.
	selection_pack u_sel_b (
		.bank_sel(func_b_bank_sel), // R15
		.pair_sel1(func_b_pair_sel1),
		.pair_sel2(func_b_pair_sel2),
		.pair_sel3(func_b_pair_sel3),
		.sel_byte0(b_sel0),
		.sel_byte1(b_sel1),
		.out_of_range(b_bad)
	);

	// ****************************************
	// Scan counter
	// ****************************************
	// The count wraps after 2^32 scans; the controller sees it as unsigned.
	assign scan_nxt = scan_r + SCAN_STEP; // R01

	// Any rst_n reset, mid-run as well as power-on, clears the count, so it always restarts at zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_r <= SCAN_RESET; // R02
		end else if (scan_done) begin
			scan_r <= scan_nxt; // R01
		end
	end

	// ****************************************
	// Snapshot
	// ****************************************
	// The new count and the fields of the same scan are assembled together.
	always_comb begin
		snap_nxt = '0;
		snap_nxt[8*(SCAN_BYTE_LAST-SCAN_BYTE_FIRST+1)-1:0] = scan_nxt; // R01
		snap_nxt[8*(A_STATUS_BYTE-SCAN_BYTE_FIRST)+:8] = a_status;
		snap_nxt[8*(A_SEL_BYTE0-SCAN_BYTE_FIRST)+:8] = a_sel0; // R08
		snap_nxt[8*(A_SEL_BYTE1-SCAN_BYTE_FIRST)+:8] = a_sel1;
		snap_nxt[8*(A_OUT_BYTE-SCAN_BYTE_FIRST)+:8] = a_out;
		snap_nxt[8*(B_STATUS_BYTE-SCAN_BYTE_FIRST)+:8] = b_status;
		snap_nxt[8*(B_SEL_BYTE0-SCAN_BYTE_FIRST)+:8] = b_sel0; // R15
		snap_nxt[8*(B_SEL_BYTE1-SCAN_BYTE_FIRST)+:8] = b_sel1;
		snap_nxt[8*(B_OUT_BYTE-SCAN_BYTE_FIRST)+:8] = b_out;
	end

	// Capture everything on one edge so the controller never sees a mixed telegram.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snap_r <= '0;
		end else if (scan_done) begin
			snap_r <= snap_nxt; // R19
		end
	end

	// Valid rises with the first completed scan and then stays.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r <= 1'b0;
			update_r <= 1'b0;
			range_err_r <= 1'b0;
		end else begin
			update_r <= scan_done;
			if (scan_done) begin
				valid_r <= 1'b1;
				range_err_r <= a_bad | b_bad;
			end
		end
	end

	// Every output is a register, so the controller never sees a glitch.
	assign telegram_bytes = snap_r;
	assign telegram_valid = valid_r;
	assign telegram_update = update_r;
	assign scan_count = scan_r;
	assign selection_range_error = range_err_r;

	// ****************************************
	// Checks
	// ****************************************
	chk_count_step: assert property (@(posedge clk) disable iff (!rst_n) // R01
		scan_done |=> scan_r == $past(scan_r) + SCAN_STEP)
		else $error("Scan count did not advance by one.");

	chk_count_hold: assert property (@(posedge clk) disable iff (!rst_n) // R01
		!scan_done |=> $stable(scan_r))
		else $error("Scan count moved without a scan.");

	chk_count_bytes: assert property (@(posedge clk) disable iff (!rst_n) // R01
		telegram_update |-> telegram_bytes[31:0] == scan_count)
		else $error("Telegram count differs from scan count.");

	chk_count_start: assert property (@(posedge clk) disable iff (!rst_n) // R02
		!telegram_valid |-> scan_count == SCAN_RESET)
		else $error("Count not zero before the first scan.");

	chk_a_active: assert property (@(posedge clk) disable iff (!rst_n) // R03
		scan_done |=> telegram_bytes[39] == $past(func_a_active))
		else $error("Function A active bit wrong.");

	chk_a_fields: assert property (@(posedge clk) disable iff (!rst_n) // R04
		scan_done |=> telegram_bytes[38:35] == $past({func_a_warn_field_state,
			func_a_prot_field_state, func_a_restart_lock, func_a_safety_switching_output}))
		else $error("Function A status bits wrong.");

	chk_a_select: assert property (@(posedge clk) disable iff (!rst_n) // R08
		scan_done |=> telegram_bytes[47:40] == $past({func_a_bank_sel, func_a_pair_sel1}))
		else $error("Function A bank or first pair wrong.");

	chk_b_status: assert property (@(posedge clk) disable iff (!rst_n) // R11
		scan_done |=> telegram_bytes[71:67] == $past({func_b_active,
			func_b_warn_field_state, func_b_prot_field_state, func_b_restart_lock,
			func_b_safety_switching_output}))
		else $error("Function B status bits wrong.");

	chk_b_outs: assert property (@(posedge clk) disable iff (!rst_n) // R16
		scan_done |=> telegram_bytes[95:90] == $past({func_b_warn_seg1_state,
			func_b_warn_seg2_state, func_b_prot_seg1_state, func_b_prot_seg2_state,
			func_b_defined_pair1_chosen, func_b_defined_pair2_chosen}))
		else $error("Function B output byte wrong.");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // R18
		telegram_bytes[34:32] == 3'h0 && telegram_bytes[57:56] == 2'h0
		&& telegram_bytes[66:64] == 3'h0 && telegram_bytes[89:88] == 2'h0)
		else $error("Reserved telegram bit not zero.");

	chk_snapshot_hold: assert property (@(posedge clk) disable iff (!rst_n) // R19
		!scan_done |=> $stable(telegram_bytes))
		else $error("Telegram changed between scans.");

	// ****************************************
	// Field checks
	// ****************************************
	// One property per field, so a failure names the field that slipped.

	// Function A, one bit or field at a time.
	chk_a_warn_bit: assert property (@(posedge clk) disable iff (!rst_n) // R04
		scan_done |=> telegram_bytes[38] == $past(func_a_warn_field_state))
		else $error("Function A warning bit wrong.");

	chk_a_prot_bit: assert property (@(posedge clk) disable iff (!rst_n) // R05
		scan_done |=> telegram_bytes[37] == $past(func_a_prot_field_state))
		else $error("Function A protective bit wrong.");

	chk_a_lock_bit: assert property (@(posedge clk) disable iff (!rst_n) // R06
		scan_done |=> telegram_bytes[36] == $past(func_a_restart_lock))
		else $error("Function A interlock bit wrong.");

	chk_a_output_bit: assert property (@(posedge clk) disable iff (!rst_n) // R07
		scan_done |=> telegram_bytes[35] == $past(func_a_safety_switching_output))
		else $error("Function A safety output bit wrong.");

	chk_a_pair_numbers: assert property (@(posedge clk) disable iff (!rst_n) // R08
		scan_done |=> telegram_bytes[55:48] == $past({func_a_pair_sel2, func_a_pair_sel3}))
		else $error("Function A second or third pair wrong.");

	chk_a_segments: assert property (@(posedge clk) disable iff (!rst_n) // R09
		scan_done |=> telegram_bytes[63:60] == $past({func_a_warn_seg1_state,
			func_a_warn_seg2_state, func_a_prot_seg1_state, func_a_prot_seg2_state}))
		else $error("Function A segment bits wrong.");

	chk_a_pair_flags: assert property (@(posedge clk) disable iff (!rst_n) // R10
		scan_done |=> telegram_bytes[59:58] == $past({func_a_defined_pair1_chosen,
			func_a_defined_pair2_chosen}))
		else $error("Function A pair flags wrong.");

	// Function B, one bit or field at a time.
	chk_b_active: assert property (@(posedge clk) disable iff (!rst_n) // R11
		scan_done |=> telegram_bytes[71] == $past(func_b_active))
		else $error("Function B active bit wrong.");

	chk_b_warn_bit: assert property (@(posedge clk) disable iff (!rst_n) // R12
		scan_done |=> telegram_bytes[70] == $past(func_b_warn_field_state))
		else $error("Function B warning bit wrong.");

	chk_b_prot_bit: assert property (@(posedge clk) disable iff (!rst_n) // R13
		scan_done |=> telegram_bytes[69] == $past(func_b_prot_field_state))
		else $error("Function B protective bit wrong.");

	chk_b_lock_output: assert property (@(posedge clk) disable iff (!rst_n) // R14
		scan_done |=> telegram_bytes[68:67] == $past({func_b_restart_lock,
			func_b_safety_switching_output}))
		else $error("Function B interlock or output bit wrong.");

	chk_b_select: assert property (@(posedge clk) disable iff (!rst_n) // R15
		scan_done |=> telegram_bytes[87:72] == $past({func_b_pair_sel2, func_b_pair_sel3,
			func_b_bank_sel, func_b_pair_sel1}))
		else $error("Function B selection bytes wrong.");

	chk_b_pair_flags: assert property (@(posedge clk) disable iff (!rst_n) // R17
		scan_done |=> telegram_bytes[91:90] == $past({func_b_defined_pair1_chosen,
			func_b_defined_pair2_chosen}))
		else $error("Function B pair flags wrong.");

	// Update pulse, valid level and range flag.
	chk_update_follows: assert property (@(posedge clk) disable iff (!rst_n) // R19
		scan_done |=> telegram_update && telegram_valid)
		else $error("Update or valid missing after a scan.");

	chk_update_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R19
		!scan_done |=> !telegram_update)
		else $error("Update raised without a scan.");

	chk_valid_hold: assert property (@(posedge clk) disable iff (!rst_n) // R01
		telegram_valid |=> telegram_valid)
		else $error("Valid fell without a reset.");

	chk_range_flag: assert property (@(posedge clk) disable iff (!rst_n) // R08 R15
		scan_done |=> selection_range_error == $past(func_a_bank_sel > SEL_MAX
			|| func_a_pair_sel1 > SEL_MAX || func_a_pair_sel2 > SEL_MAX
			|| func_a_pair_sel3 > SEL_MAX || func_b_bank_sel > SEL_MAX
			|| func_b_pair_sel1 > SEL_MAX || func_b_pair_sel2 > SEL_MAX
			|| func_b_pair_sel3 > SEL_MAX))
		else $error("Range flag does not match the selections.");

	chk_range_hold: assert property (@(posedge clk) disable iff (!rst_n) // R19
		!scan_done |=> $stable(selection_range_error))
		else $error("Range flag changed between scans.");
endmodule : scanner_status_telegram_builder

// ---- pkg/telegram_pkg.sv ----
package telegram_pkg;
	// ****************************************
	// Telegram layout
	// ****************************************
	// Byte numbers of the telegram fields and the section length in bytes.
	localparam int unsigned SCAN_BYTE_FIRST = 8;
	localparam int unsigned SCAN_BYTE_LAST = 11;
	localparam int unsigned A_STATUS_BYTE = 12;
	localparam int unsigned A_SEL_BYTE0 = 13;
	localparam int unsigned A_SEL_BYTE1 = 14;
	localparam int unsigned A_OUT_BYTE = 15;
	localparam int unsigned B_STATUS_BYTE = 16;
	localparam int unsigned B_SEL_BYTE0 = 17;
	localparam int unsigned B_SEL_BYTE1 = 18;
	localparam int unsigned B_OUT_BYTE = 19;
	localparam int unsigned SECTION_BYTES = 12;

	// Bit positions inside a status byte.
	localparam int unsigned ST_ACTIVE_BIT = 7;
	localparam int unsigned ST_WARN_BIT = 6;
	localparam int unsigned ST_PROT_BIT = 5;
	localparam int unsigned ST_LOCK_BIT = 4;
	localparam int unsigned ST_OUTPUT_BIT = 3;

	// Bit positions inside an output-signal byte.
	localparam int unsigned OS_WARN_SEG1_BIT = 7;
	localparam int unsigned OS_WARN_SEG2_BIT = 6;
	localparam int unsigned OS_PROT_SEG1_BIT = 5;
	localparam int unsigned OS_PROT_SEG2_BIT = 4;
	localparam int unsigned OS_PAIR1_BIT = 3;
	localparam int unsigned OS_PAIR2_BIT = 2;

	// Reset values, count step and selection limits.
	localparam logic [31:0] SCAN_RESET = 32'h0000_0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] SCAN_STEP = 32'h0000_0001;
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	localparam logic [3:0] SEL_MIN = 4'h1;
	localparam logic [3:0] SEL_MAX = 4'hA;
endpackage : telegram_pkg

// ---- src/status_byte_pack.sv ----
`timescale 1ns/10ps
// Packs one protective function's status and output-signal bytes; reserved bits are zero.
module status_byte_pack (
	// Status inputs.
	input wire logic active,
	input wire logic warn_field_state,
	input wire logic prot_field_state,
	input wire logic restart_lock,
	input wire logic safety_switching_output,
	// Segment and pair inputs.
	input wire logic warn_seg1_state,
	input wire logic warn_seg2_state,
	input wire logic prot_seg1_state,
	input wire logic prot_seg2_state,
	input wire logic defined_pair1_chosen,
	input wire logic defined_pair2_chosen,
	// Packed bytes.
	output logic [7:0] status_byte,
	output logic [7:0] out_byte
);
	import telegram_pkg::*;

	// ****************************************
	// Byte assembly
	// ****************************************
	// Start from zero so every reserved position leaves as zero.
	always_comb begin
		status_byte = BYTE_RESET; // R18
		status_byte[ST_ACTIVE_BIT] = active;
		status_byte[ST_WARN_BIT] = warn_field_state;
		status_byte[ST_PROT_BIT] = prot_field_state;
		status_byte[ST_LOCK_BIT] = restart_lock;
		status_byte[ST_OUTPUT_BIT] = safety_switching_output;
		out_byte = BYTE_RESET; // R18
		out_byte[OS_WARN_SEG1_BIT] = warn_seg1_state;
		out_byte[OS_WARN_SEG2_BIT] = warn_seg2_state;
		out_byte[OS_PROT_SEG1_BIT] = prot_seg1_state;
		out_byte[OS_PROT_SEG2_BIT] = prot_seg2_state;
		out_byte[OS_PAIR1_BIT] = defined_pair1_chosen;
		out_byte[OS_PAIR2_BIT] = defined_pair2_chosen;
	end
endmodule : status_byte_pack

// ---- src/selection_pack.sv ----
`timescale 1ns/10ps
// Packs bank and three pair numbers into two bytes, flagging nonzero numbers outside 1 to 10.
module selection_pack (
	// Selection inputs.
	input wire logic [3:0] bank_sel,
	input wire logic [3:0] pair_sel1,
	input wire logic [3:0] pair_sel2,
	input wire logic [3:0] pair_sel3,
	// Packed bytes and range flag.
	output logic [7:0] sel_byte0,
	output logic [7:0] sel_byte1,
	output logic out_of_range
);
	import telegram_pkg::*;

	logic [3:0] nib [4];
	logic [3:0] bad;

	assign nib[0] = bank_sel;
	assign nib[1] = pair_sel1;
	assign nib[2] = pair_sel2;
	assign nib[3] = pair_sel3;

	// ****************************************
	// Range check
	// ****************************************
	// Zero is the default before any selection, so it is accepted as well.
	for (genvar i = 0; i < 4; i++) begin : g_rng
		assign bad[i] = (nib[i] != NIBBLE_RESET) && ((nib[i] < SEL_MIN) || (nib[i] > SEL_MAX));
	end

	// Bank sits in the high nibble of the first byte.
	assign sel_byte0 = {bank_sel, pair_sel1};
	assign sel_byte1 = {pair_sel2, pair_sel3};
	assign out_of_range = |bad;
endmodule : selection_pack

// ---- verif/telegram_reader.sv ----
`timescale 1ns/10ps
// ****************************************
// Network controller side
// ****************************************
// Takes each telegram on the update pulse and counts them, as the far controller would.
module telegram_reader (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Telegram from the builder.
	input wire logic [8*telegram_pkg::SECTION_BYTES-1:0] telegram_bytes,
	input wire logic telegram_update,
	// What the controller has taken.
	output logic [8*telegram_pkg::SECTION_BYTES-1:0] snap_r,
	output logic [31:0] total_r
);
	import telegram_pkg::*;
	// The whole telegram is taken in one edge, so its count and status never mix scans.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snap_r <= '0;
			total_r <= 32'h0000_0000;
		end else if (telegram_update) begin
			snap_r <= telegram_bytes;
			total_r <= total_r + 32'h0000_0001;
		end
	end
endmodule : telegram_reader

// ---- verif/scanner_status_telegram_builder_tb_top.sv ----
`timescale 1ns/10ps
// ****************************************
// Telegram builder bench
// ****************************************
module scanner_status_telegram_builder_tb_top;
	import telegram_pkg::*;
	logic clk;
	logic rst_n;
	logic scan_done;
	logic [10:0] a_bits;
	logic [10:0] b_bits;
	logic [15:0] a_sel;
	logic [15:0] b_sel;
	logic [8*SECTION_BYTES-1:0] tel;
	logic tel_valid;
	logic tel_update;
	logic range_err;
	logic [31:0] scan_count;
	logic [8*SECTION_BYTES-1:0] snap;
	logic [31:0] total;
	logic [31:0] exp_count;
	int n_mismatch;
	int check_count;
	int cycles;
	int i;

	scanner_status_telegram_builder scanner_status_telegram_builder_i (
		.clk(clk), .rst_n(rst_n), .scan_done(scan_done),
		.func_a_active(a_bits[10]), .func_a_warn_field_state(a_bits[9]),
		.func_a_prot_field_state(a_bits[8]), .func_a_restart_lock(a_bits[7]),
		.func_a_safety_switching_output(a_bits[6]),
		.func_a_bank_sel(a_sel[15:12]), .func_a_pair_sel1(a_sel[11:8]),
		.func_a_pair_sel2(a_sel[7:4]), .func_a_pair_sel3(a_sel[3:0]),
		.func_a_warn_seg1_state(a_bits[5]), .func_a_warn_seg2_state(a_bits[4]),
		.func_a_prot_seg1_state(a_bits[3]), .func_a_prot_seg2_state(a_bits[2]),
		.func_a_defined_pair1_chosen(a_bits[1]), .func_a_defined_pair2_chosen(a_bits[0]),
		.func_b_active(b_bits[10]), .func_b_warn_field_state(b_bits[9]),
		.func_b_prot_field_state(b_bits[8]), .func_b_restart_lock(b_bits[7]),
		.func_b_safety_switching_output(b_bits[6]),
		.func_b_bank_sel(b_sel[15:12]), .func_b_pair_sel1(b_sel[11:8]),
		.func_b_pair_sel2(b_sel[7:4]), .func_b_pair_sel3(b_sel[3:0]),
		.func_b_warn_seg1_state(b_bits[5]), .func_b_warn_seg2_state(b_bits[4]),
		.func_b_prot_seg1_state(b_bits[3]), .func_b_prot_seg2_state(b_bits[2]),
		.func_b_defined_pair1_chosen(b_bits[1]), .func_b_defined_pair2_chosen(b_bits[0]),
		.telegram_bytes(tel), .telegram_valid(tel_valid), .telegram_update(tel_update),
		.scan_count(scan_count), .selection_range_error(range_err)
	);

	telegram_reader telegram_reader_i (
		.clk(clk), .rst_n(rst_n), .telegram_bytes(tel), .telegram_update(tel_update),
		.snap_r(snap), .total_r(total)
	);

	// A 50 ns clock; the bench never samples on its edge.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Compares one value and counts the result.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Presents one scan; the outputs are settled when this returns.
	task scan(input logic [10:0] a, input logic [10:0] b, input logic [15:0] sa,
		input logic [15:0] sb);
		@(posedge clk);
		a_bits <= a;
		b_bits <= b;
		a_sel <= sa;
		b_sel <= sb;
		scan_done <= 1'b1;
		@(posedge clk);
		scan_done <= 1'b0;
		exp_count = exp_count + 32'h0000_0001;
		#1;
	endtask : scan

	// Checks the whole telegram against what the inputs of the last scan demand.
	task check_tel(input logic [10:0] a, input logic [10:0] b, input logic [15:0] sa,
		input logic [15:0] sb);
		check(32'(tel_update), 32'h0000_0001);
		check(32'(tel_valid), 32'h0000_0001);
		check(tel[31:0], exp_count);
		check(scan_count, exp_count);
		check(32'(tel[39:32]), 32'({a[10:6], 3'b000}));
		check(32'(tel[55:40]), 32'({sa[7:0], sa[15:8]}));
		check(32'(tel[63:56]), 32'({a[5:0], 2'b00}));
		check(32'(tel[71:64]), 32'({b[10:6], 3'b000}));
		check(32'(tel[87:72]), 32'({sb[7:0], sb[15:8]}));
		check(32'(tel[95:88]), 32'({b[5:0], 2'b00}));
	endtask : check_tel

	// Prints the counts and the verdict, then ends the run.
	task conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	// The run needs under a hundred cycles; a hang is cut off well beyond that.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		rst_n = 1'b0;
		scan_done = 1'b0;
		a_bits = 11'h000;
		b_bits = 11'h000;
		a_sel = 16'h0000;
		b_sel = 16'h0000;
		exp_count = 32'h0000_0000;
		n_mismatch = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check(32'(tel != '0), 32'h0000_0000);
		check(scan_count, 32'h0000_0000);
		check(32'({tel_valid, tel_update, range_err}), 32'h0000_0000);
		// Walk a single one through A and a single zero through B.
		for (i = 0; i < 11; i++) begin
			scan(11'h001 << i, ~(11'h001 << i), {4'(i % 10 + 1), 12'hA15}, 16'h2937);
			check_tel(11'h001 << i, ~(11'h001 << i), {4'(i % 10 + 1), 12'hA15}, 16'h2937);
			check(32'(range_err), 32'h0000_0000);
		end
		// Inputs moving between scans must not reach the telegram.
		@(posedge clk);
		a_bits <= 11'h7FF;
		b_bits <= 11'h000;
		repeat (3) @(posedge clk);
		#1;
		check(32'(tel_update), 32'h0000_0000);
		check(32'(tel[39:32]), 32'h0000_0080);
		// Two scans back to back advance the count twice.
		@(posedge clk);
		scan_done <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		scan_done <= 1'b0;
		exp_count = exp_count + 32'h0000_0002;
		#1;
		check(scan_count, exp_count);
		check(tel[31:0], exp_count);
		check(32'(tel[39:32]), 32'h0000_00F8);
		// Selection numbers just outside and on the limits.
		scan(11'h7FF, 11'h7FF, 16'hB123, 16'hA000);
		check_tel(11'h7FF, 11'h7FF, 16'hB123, 16'hA000);
		check(32'(range_err), 32'h0000_0001);
		scan(11'h000, 11'h000, 16'hA000, 16'h123C);
		check(32'(range_err), 32'h0000_0001);
		@(posedge clk);
		#1;
		check(total, exp_count);
		// A reset in mid-run clears the count and counting restarts at one.
		@(posedge clk);
		rst_n <= 1'b0;
		#1;
		check(scan_count, 32'h0000_0000);
		check(32'(tel_valid), 32'h0000_0000);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		exp_count = 32'h0000_0000;
		scan(11'h555, 11'h2AA, 16'h1234, 16'h5678);
		check_tel(11'h555, 11'h2AA, 16'h1234, 16'h5678);
		@(posedge clk);
		#1;
		check(snap[63:32], 32'h5434_12A8);
		check(snap[31:0], 32'h0000_0001);
		conclude();
	end
endmodule : scanner_status_telegram_builder_tb_top
